// [design/pwr_ctl_pkg.sv]
package pwr_ctl_pkg;
  // Mode one-hot codes
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_SLEEP = 5'h02,
    ST_SWSTBY = 5'h04,
    ST_SETTLE = 5'h08,
    ST_HWSTBY = 5'h10
  } pmode_t;
  // Internal RAM windows
  localparam logic [19:0] RAM_SMALL_LO = 20'hff710;
  localparam logic [19:0] RAM_LARGE_LO = 20'hfef10;
  localparam logic [19:0] RAM_HI = 20'hfff0f;
  // Prescaler width: divides up to 4096
  localparam int PRE_W = 12;
  // Duty correction threshold in kHz
  localparam int DUTY_KHZ = 5000;
  // Settling waits in states, by select code
  localparam logic [17:0] WAIT_0 = 18'h02000;
  localparam logic [17:0] WAIT_1 = 18'h04000;
  localparam logic [17:0] WAIT_2 = 18'h08000;
  localparam logic [17:0] WAIT_3 = 18'h10000;
  localparam logic [17:0] WAIT_4 = 18'h20000;
  // Reset wait for external clock, in ns, and cycles at 25 ns
  localparam int EXT_SETTLE_NS = 500000;
  localparam int CLK_NS = 25;
  localparam int EXT_SETTLE_CYC = (EXT_SETTLE_NS + CLK_NS - 1) / CLK_NS;
endpackage : pwr_ctl_pkg

// [design/pin_sync_if.sv]
`timescale 1ns/10ps
`default_nettype none
// Raw and filtered pin levels between top and synchroniser
interface pin_sync_if;
  logic [5:0] raw;
  logic [5:0] clean;
  modport top (output raw, input clean);
  modport sync (input raw, output clean);
endinterface : pin_sync_if
`default_nettype wire

// [design/pin_sync.sv]
`timescale 1ns/10ps
`default_nettype none
// Three-stage synchroniser; level changes once stages 2 and 3 agree
module pin_sync (
  input wire logic clk,
  input wire logic reset,
  pin_sync_if.sync p
);
  // Reset to each pin's idle level: low-active pins high, NMI low,
  // so the NMI edge detector sees no false rise after reset
  localparam logic [5:0] IDLE = 6'h37;
  logic [5:0] s1_ff;
  logic [5:0] s2_ff;
  logic [5:0] s3_ff;
  logic [5:0] clean_ff;
  logic [5:0] agree;
  logic [5:0] nxt_clean;
  // Bits where second and third stages match
  assign agree = ~(s2_ff ^ s3_ff);
  assign nxt_clean = (agree & s3_ff) | (~agree & clean_ff);
  assign p.clean = clean_ff;
  // Shift chain
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_ff <= IDLE;
      s2_ff <= IDLE;
      s3_ff <= IDLE;
      clean_ff <= IDLE;
    end else begin
      s1_ff <= p.raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      clean_ff <= nxt_clean;
    end
  end
endmodule : pin_sync
`default_nettype wire

// [design/power_down_and_clock_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
// Power-down sequencer, prescaler and RAM steering
module power_down_and_clock_ctrl #(
  parameter bit LARGE_MEM = 1'b0,
  parameter int OSC_KHZ = 40000,
  parameter logic [17:0] WAIT_SCALE_SHIFT = 18'h0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic chip_rst_pin_n,
  input wire logic hw_halt_pin_n,
  input wire logic nmi_pin,
  input wire logic [2:0] irq_pin_n,
  input wire logic [2:0] irq_enable,
  input wire logic int_request,
  input wire logic halt_exec,
  input wire logic onchip_mem_en,
  input wire logic deep_sleep_select,
  input wire logic [2:0] wake_wait_select,
  input wire logic [19:0] cpu_addr,
  output logic cpu_halted,
  output logic clk_run,
  output logic periph_rst,
  output logic ports_hiz,
  output logic wake_int,
  output logic ram_sel,
  output logic ext_sel,
  output logic duty_fix_on,
  output logic [pwr_ctl_pkg::PRE_W-1:0] presc_tick,
  output logic [4:0] mode_state
);
  localparam int PRE_W_OUT = pwr_ctl_pkg::PRE_W;
  // Pin synchroniser link
  pin_sync_if pins ();
  assign pins.raw = {chip_rst_pin_n, hw_halt_pin_n, nmi_pin, irq_pin_n};
  pin_sync u_sync (
    .clk(clk),
    .reset(reset),
    .p(pins)
  );
  // Filtered pin levels
  wire rst_n_s = pins.clean[5];
  wire hw_halt_pin_n_n_s = pins.clean[4];
  wire nmi_s = pins.clean[3];
  wire [2:0] irq_n_s = pins.clean[2:0];
  // Rising NMI edge detect on filtered level
  logic nmi_d_ff;
  wire nmi_edge = nmi_s & ~nmi_d_ff;
  // Light sleep wakes on int_request alone; deep sleep only on these pins
  // limited wake set
  wire deep_wake = nmi_edge | (|(~irq_n_s & irq_enable));
  // Settle wait lookup by select code
  function automatic logic [17:0] wait_len(input logic [2:0] sel);
    case (sel)
      3'h0: wait_len = pwr_ctl_pkg::WAIT_0;
      3'h1: wait_len = pwr_ctl_pkg::WAIT_1;
      3'h2: wait_len = pwr_ctl_pkg::WAIT_2;
      3'h3: wait_len = pwr_ctl_pkg::WAIT_3;
      // Illegal codes treated as longest wait, the safe side
      default: wait_len = pwr_ctl_pkg::WAIT_4;
    endcase
  endfunction : wait_len
  // Mode state machine
  pwr_ctl_pkg::pmode_t state_ff, nxt_state;
  logic [17:0] wait_ff, nxt_wait;
  // Shift parameter shortens the settle wait, meant for simulation only
  wire [17:0] wait_load = wait_len(wake_wait_select) >> WAIT_SCALE_SHIFT;
  always_comb begin
    nxt_state = state_ff;
    nxt_wait = wait_ff;
    if (!hw_halt_pin_n_n_s) begin
      nxt_state = pwr_ctl_pkg::ST_HWSTBY;
    end else if (!rst_n_s) begin
      nxt_state = pwr_ctl_pkg::ST_RUN;
    end else begin
      case (state_ff)
        pwr_ctl_pkg::ST_RUN: begin
          if (halt_exec && deep_sleep_select) begin
            nxt_state = pwr_ctl_pkg::ST_SWSTBY;
          end else if (halt_exec) begin
            nxt_state = pwr_ctl_pkg::ST_SLEEP;
          end
        end
        pwr_ctl_pkg::ST_SLEEP: begin
          if (int_request) begin
            nxt_state = pwr_ctl_pkg::ST_RUN;
          end
        end
        pwr_ctl_pkg::ST_SWSTBY: begin
          if (deep_wake) begin
            nxt_state = pwr_ctl_pkg::ST_SETTLE;
            nxt_wait = (wait_load == 18'h0) ? 18'h1 : wait_load;
          end
        end
        pwr_ctl_pkg::ST_SETTLE: begin
          nxt_wait = wait_ff - 18'h1;
          if (wait_ff == 18'h1) begin
            nxt_state = pwr_ctl_pkg::ST_RUN;
          end
        end
        pwr_ctl_pkg::ST_HWSTBY: nxt_state = pwr_ctl_pkg::ST_HWSTBY;
        default: nxt_state = pwr_ctl_pkg::ST_RUN;
      endcase
    end
  end
  // State and wake pulse registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= pwr_ctl_pkg::ST_RUN;
      wait_ff <= 18'h0;
      nmi_d_ff <= 1'b0;
      wake_int <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      wait_ff <= nxt_wait;
      nmi_d_ff <= nmi_s;
      // Pulse rises with the return to run, so handling sees a stable clock
      wake_int <= (state_ff == pwr_ctl_pkg::ST_SETTLE) &&
                  (nxt_state == pwr_ctl_pkg::ST_RUN);
    end
  end
  // mode outputs, all low modes halt CPU
  wire nxt_halted = (nxt_state != pwr_ctl_pkg::ST_RUN);
  wire nxt_clk_stop = (nxt_state == pwr_ctl_pkg::ST_SWSTBY) ||
                      (nxt_state == pwr_ctl_pkg::ST_HWSTBY);
  wire [19:0] ram_lo = LARGE_MEM ? pwr_ctl_pkg::RAM_LARGE_LO
                                 : pwr_ctl_pkg::RAM_SMALL_LO;
  wire in_ram = (cpu_addr >= ram_lo) && (cpu_addr <= pwr_ctl_pkg::RAM_HI);
  wire nxt_ram_sel = in_ram & onchip_mem_en;
  // free-running prescaler, cleared to zero in stop modes
  logic [PRE_W_OUT-1:0] pre_ff;
  wire [PRE_W_OUT-1:0] nxt_pre = pre_ff + 1'b1;
  always_ff @(posedge clk) begin
    if (reset) begin
      pre_ff <= '0;
      presc_tick <= '0;
      cpu_halted <= 1'b0;
      clk_run <= 1'b1;
      periph_rst <= 1'b0;
      ports_hiz <= 1'b0;
      ram_sel <= 1'b0;
      ext_sel <= 1'b0;
      duty_fix_on <= 1'b0;
      mode_state <= pwr_ctl_pkg::ST_RUN;
    end else begin
      pre_ff <= nxt_clk_stop ? '0 : nxt_pre;
      // Bit k pulses every 2^(k+1) cycles
      presc_tick <= nxt_clk_stop ? '0 : (nxt_pre & ~pre_ff);
      cpu_halted <= nxt_halted;
      clk_run <= ~nxt_clk_stop;
      periph_rst <= nxt_clk_stop;
      ports_hiz <= (nxt_state == pwr_ctl_pkg::ST_HWSTBY);
      ram_sel <= nxt_ram_sel;
      ext_sel <= in_ram & ~onchip_mem_en | ~in_ram;
      duty_fix_on <= (OSC_KHZ >= pwr_ctl_pkg::DUTY_KHZ);
      mode_state <= nxt_state;
    end
  end
  // Checks
  AST_HW_HW_HALT_PIN_N_FLOAT: assert property (@(posedge clk) disable iff (reset)
    !hw_halt_pin_n_n_s |=> ports_hiz && periph_rst && cpu_halted)
    else $error("standby pin did not float ports");
  AST_SLEEP_ENTRY: assert property (@(posedge clk) disable iff (reset)
    state_ff == pwr_ctl_pkg::ST_RUN && halt_exec && !deep_sleep_select
    && hw_halt_pin_n_n_s && rst_n_s |=> cpu_halted && clk_run)
    else $error("light sleep entry wrong");
  AST_DEEP_ENTRY: assert property (@(posedge clk) disable iff (reset)
    state_ff == pwr_ctl_pkg::ST_RUN && halt_exec && deep_sleep_select
    && hw_halt_pin_n_n_s && rst_n_s |=> !clk_run && periph_rst)
    else $error("deep sleep entry wrong");
  AST_SLEEP_EXIT: assert property (@(posedge clk) disable iff (reset)
    state_ff == pwr_ctl_pkg::ST_SLEEP && int_request && hw_halt_pin_n_n_s
    && rst_n_s |=> !cpu_halted)
    else $error("light sleep did not end");
  AST_DEEP_IGNORE: assert property (@(posedge clk) disable iff (reset)
    state_ff == pwr_ctl_pkg::ST_SWSTBY && !deep_wake && hw_halt_pin_n_n_s
    && rst_n_s |=> state_ff == pwr_ctl_pkg::ST_SWSTBY)
    else $error("deep sleep left on wrong source");
  AST_SETTLE_HOLD: assert property (@(posedge clk) disable iff (reset)
    state_ff == pwr_ctl_pkg::ST_SETTLE && wait_ff > 18'h1 && hw_halt_pin_n_n_s
    && rst_n_s |=> state_ff == pwr_ctl_pkg::ST_SETTLE
    && wait_ff == $past(wait_ff) - 18'h1)
    else $error("settle count broken");
  AST_RAM_ROUTE: assert property (@(posedge clk) disable iff (reset)
    onchip_mem_en && cpu_addr == pwr_ctl_pkg::RAM_HI |=> ram_sel)
    else $error("ram window not routed");
  AST_RAM_LOW: assert property (@(posedge clk) disable iff (reset)
    onchip_mem_en && cpu_addr == ram_lo |=> ram_sel && !ext_sel)
    else $error("ram window low edge wrong");
  AST_RAM_OFF: assert property (@(posedge clk) disable iff (reset)
    !onchip_mem_en |=> !ram_sel && ext_sel)
    else $error("disabled ram not external");
  AST_HW_STAYS: assert property (@(posedge clk) disable iff (reset)
    state_ff == pwr_ctl_pkg::ST_HWSTBY && hw_halt_pin_n_n_s && rst_n_s && int_request
    |=> state_ff == pwr_ctl_pkg::ST_HWSTBY)
    else $error("hardware standby left by interrupt");
  AST_TICK_LOW: assert property (@(posedge clk) disable iff (reset)
    clk_run && presc_tick[0] |=> !presc_tick[0])
    else $error("half-rate tick wrong");
  // Forced exit by the reset pin and the end of the settle wait
  AST_RST_PIN_RUN: assert property (@(posedge clk) disable iff (reset)
    hw_halt_pin_n_n_s && !rst_n_s |=> !cpu_halted && clk_run)
    else $error("reset pin did not return to run");
  AST_WAKE_PULSE: assert property (@(posedge clk) disable iff (reset)
    state_ff == pwr_ctl_pkg::ST_SETTLE && wait_ff == 18'h1 && hw_halt_pin_n_n_s
    && rst_n_s |=> wake_int && !cpu_halted)
    else $error("settle end gave no wake pulse");
  COV_SLEEP: cover property (@(posedge clk)
    state_ff == pwr_ctl_pkg::ST_SLEEP ##1 state_ff == pwr_ctl_pkg::ST_RUN);
  COV_DEEP: cover property (@(posedge clk)
    state_ff == pwr_ctl_pkg::ST_SETTLE ##1 state_ff == pwr_ctl_pkg::ST_RUN);
  COV_HW: cover property (@(posedge clk) state_ff == pwr_ctl_pkg::ST_HWSTBY);
  COV_RAM: cover property (@(posedge clk) ram_sel);
endmodule : power_down_and_clock_ctrl
`default_nettype wire

// [testbench/pin_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Far side: board logic that drives the reset and standby pins
module pin_model #(
  parameter int HOLD = 16
) (
  input wire logic clk,
  input wire logic rst_req,
  input wire logic hw_halt_pin_n_req,
  output logic chip_rst_pin_n,
  output logic hw_halt_pin_n
);
  int cnt_ff = 0; // Cycles since the clock started, up to HOLD
  always @(posedge clk) begin
    if (cnt_ff < HOLD) begin
      cnt_ff <= cnt_ff + 1;
    end
  end
  assign chip_rst_pin_n = !rst_req && (cnt_ff >= HOLD);
  // Standby pin has a pull-up, so it idles high
  assign hw_halt_pin_n = !hw_halt_pin_n_req;
endmodule : pin_model
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 0, reset = 1, rst_req = 0, hw_halt_pin_n_req = 0, nmi = 0, intr = 0;
  logic halt = 0, mem_en = 0, dsel = 0;
  logic [2:0] irq_n = 3'h7, irq_en = 3'h0, wsel = 3'h0;
  logic [19:0] addr = 20'h0;
  logic rst_n, hw_halt_pin_n_n, halted, clk_run, prst, hiz, wake, ram, ext, duty;
  logic [11:0] tick;
  logic [4:0] mode;
  logic [19:0] av [4] = '{20'hff70f, 20'hff710, 20'hfff0f, 20'hfff10};
  logic [19:0] al [4] = '{20'hfef0f, 20'hfef10, 20'hfff0f, 20'hfff10};
  logic ram_l, ext_l;
  logic rv [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  int error_cnt = 0, compares = 0, n, c0, c11;
  // Free-running 40 MHz clock
  always #12.5 clk = ~clk;
  pin_model #(.HOLD(pwr_ctl_pkg::EXT_SETTLE_CYC)) u_pins (.clk(clk),
    .rst_req(rst_req), .hw_halt_pin_n_req(hw_halt_pin_n_req), .chip_rst_pin_n(rst_n),
    .hw_halt_pin_n(hw_halt_pin_n_n));
  // Settle counts shortened by 2^10 to keep the run short
  power_down_and_clock_ctrl #(.WAIT_SCALE_SHIFT(18'ha)) u_dut (.clk(clk),
    .reset(reset), .chip_rst_pin_n(rst_n), .hw_halt_pin_n(hw_halt_pin_n_n),
    .nmi_pin(nmi), .irq_pin_n(irq_n), .irq_enable(irq_en),
    .int_request(intr), .halt_exec(halt), .onchip_mem_en(mem_en),
    .deep_sleep_select(dsel), .wake_wait_select(wsel), .cpu_addr(addr),
    .cpu_halted(halted), .clk_run(clk_run), .periph_rst(prst),
    .ports_hiz(hiz), .wake_int(wake), .ram_sel(ram), .ext_sel(ext),
    .duty_fix_on(duty), .presc_tick(tick), .mode_state(mode));
  // Larger-memory variant, watched only for its RAM window
  power_down_and_clock_ctrl #(.LARGE_MEM(1'b1), .WAIT_SCALE_SHIFT(18'ha))
    u_big (.clk(clk), .reset(reset), .chip_rst_pin_n(rst_n),
    .hw_halt_pin_n(hw_halt_pin_n_n), .nmi_pin(nmi), .irq_pin_n(irq_n),
    .irq_enable(irq_en), .int_request(intr), .halt_exec(halt),
    .onchip_mem_en(mem_en), .deep_sleep_select(dsel),
    .wake_wait_select(wsel), .cpu_addr(addr), .cpu_halted(),
    .clk_run(), .periph_rst(), .ports_hiz(), .wake_int(), .ram_sel(ram_l),
    .ext_sel(ext_l), .duty_fix_on(), .presc_tick(), .mode_state());
  // Verdict and end of run
  task automatic summarize();
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Let k edges pass, then sample settled outputs
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  // One-cycle halt instruction with the given select bit
  task automatic halt_op(input logic sel);
    @(posedge clk);
    dsel <= sel;
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
  endtask : halt_op
  // Bounded wait for a mode; n keeps the cycles spent
  task automatic wait_mode(input logic [4:0] m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin
      cyc(1);
      n++;
    end
    chk(mode, m);
  endtask : wait_mode
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    cyc(pwr_ctl_pkg::EXT_SETTLE_CYC + 8);
    chk(duty, 1'b1);
    chk({clk_run, halted, mode}, 7'h41);
    @(posedge clk);
    mem_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      addr <= av[i];
      cyc(2);
      chk({ram, ext}, {rv[i], !rv[i]});
    end
    // Same edges of the larger window, seen by the second instance
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      addr <= al[i];
      cyc(2);
      chk({ram_l, ext_l}, {rv[i], !rv[i]});
    end
    @(posedge clk);
    mem_en <= 1'b0;
    addr <= 20'hff710;
    cyc(2);
    chk({ram, ext}, 2'b01);
    chk({ram_l, ext_l}, 2'b01);
    c0 = 0;
    c11 = 0;
    repeat (8192) begin
      cyc(1);
      c0 += tick[0];
      c11 += tick[11];
    end
    chk(c0, 4096);
    chk(c11, 2);
    halt_op(1'b0);
    cyc(1);
    chk({halted, clk_run, mode}, 7'h62);
    @(posedge clk);
    intr <= 1'b1;
    @(posedge clk);
    intr <= 1'b0;
    wait_mode(5'h01, 4);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      wsel <= k ? 3'h4 : 3'h0;
      irq_en <= 3'h1;
      halt_op(1'b1);
      cyc(1);
      chk({clk_run, prst, mode}, 7'h24);
      @(posedge clk);
      intr <= 1'b1;
      cyc(8);
      chk(mode, 5'h04);
      @(posedge clk);
      intr <= 1'b0;
      if (k == 0) nmi <= 1'b1;
      else irq_n <= 3'h6;
      wait_mode(5'h08, 8);
      wait_mode(5'h01, 200);
      chk(n >= (k ? 127 : 7) && n <= (k ? 130 : 10), 1'b1);
      chk({wake, clk_run}, 2'b11);
      cyc(1);
      chk(wake, 1'b0);
      @(posedge clk);
      nmi <= 1'b0;
      irq_n <= 3'h7;
      cyc(8);
    end
    halt_op(1'b0);
    // memory enable cleared in the same step as the standby pin request
    mem_en <= 1'b0;
    hw_halt_pin_n_req <= 1'b1;
    wait_mode(5'h10, 8);
    chk({hiz, prst, clk_run}, 3'b110);
    @(posedge clk);
    rst_req <= 1'b1;
    cyc(8);
    chk(mode, 5'h10);
    @(posedge clk);
    rst_req <= 1'b0;
    intr <= 1'b1;
    cyc(8);
    chk(mode, 5'h10);
    @(posedge clk);
    hw_halt_pin_n_req <= 1'b0;
    cyc(8);
    chk(mode, 5'h10);
    @(posedge clk);
    intr <= 1'b0;
    rst_req <= 1'b1;
    wait_mode(5'h01, 8);
    @(posedge clk);
    rst_req <= 1'b0;
    cyc(8);
    halt_op(1'b0);
    cyc(1);
    chk(mode, 5'h02);
    @(posedge clk);
    rst_req <= 1'b1;
    wait_mode(5'h01, 8);
    @(posedge clk);
    rst_req <= 1'b0;
    cyc(8);
    summarize();
  end
  // Watchdog: about twice the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule : tb
`default_nettype wire
